//--- verification/package_idle_state_resolver_tb.sv
// self-checking bench of the package idle-state resolver
`default_nettype none
module package_idle_state_resolver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [11:0] core_state = 12'h000;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF, core_break = 4'h0, core_break_masked = 4'h0;
  logic [3:0] want = 4'h0, lag = 4'h0, core_wake, break_forward, standby_permit;
  logic [2:0] pkg_state;
  logic [1:0] bresp, rresp;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, mem_break = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pkg_ack, l2_powered, core_volt_off, sa_power_off;
  logic core_clk_min, core_volt_low, plat_grant, plat_grant_deep, plat_grant_deepest, plat_hold_high;
  int err_count = 0, n_checks = 0, cycles = 0;
  package_idle_state_resolver u_package_idle_state_resolver (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .core_state(core_state), .core_break(core_break), .core_break_masked(core_break_masked),
    .core_wake(core_wake), .break_forward(break_forward), .standby_permit(standby_permit),
    .plat_grant(plat_grant), .plat_grant_deep(plat_grant_deep), .plat_grant_deepest(plat_grant_deepest),
    .plat_hold_high(plat_hold_high), .mem_break(mem_break), .pkg_ack(pkg_ack), .pkg_state(pkg_state),
    .l2_powered(l2_powered), .core_volt_off(core_volt_off), .sa_power_off(sa_power_off),
    .core_clk_min(core_clk_min), .core_volt_low(core_volt_low));
  platform_ctrl_model u_platform_ctrl_model (
    .aclk(aclk), .aresetn(aresetn), .want(want), .lag(lag), .pkg_ack(pkg_ack), .plat_grant(plat_grant),
    .plat_grant_deep(plat_grant_deep), .plat_grant_deepest(plat_grant_deepest), .plat_hold_high(plat_hold_high));
  // ********
  // helpers
  // ********
  always #50 aclk = ~aclk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // hang guard
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      report_and_stop;
    end
  end
  // bus write, each channel released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      got = bvalid;
    end
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'b0;
  endtask
  // bus read
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      got = rvalid;
    end
    chk("rdata", ed, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'b0;
  endtask
  // apply core requests and wanted levels, then judge the state
  task automatic settle(input logic [11:0] cs, input logic [3:0] w, input logic [2:0] exp, input string what);
    @(posedge aclk);
    core_state <= cs;
    want <= w;
    repeat (20) @(posedge aclk);
    chk(what, {29'h0, exp}, {29'h0, pkg_state});
  endtask
  // one-cycle break pulse, returns when its answer is visible
  task automatic pulse(input logic [3:0] cb, input logic [3:0] cm, input logic mb);
    @(posedge aclk);
    core_break <= cb;
    core_break_masked <= cm;
    mem_break <= mb;
    @(posedge aclk);
    core_break <= 4'h0;
    mem_break <= 1'b0;
    @(posedge aclk);
    chk("wake", {28'h0, cb}, {28'h0, core_wake});
    chk("forward", {28'h0, cb}, {28'h0, break_forward});
    chk("break state", 32'h0, {29'h0, pkg_state});
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_regs;
    axi_rd(4'h0, 32'h0, 2'h0);
    axi_rd(4'h8, 32'h40, 2'h0);
    axi_wr(4'h8, 32'h1234, 2'h0);
    axi_rd(4'h8, 32'h1234, 2'h0);
    axi_wr(4'h8, 32'h40, 2'h0);
    axi_wr(4'h2, 32'hF, 2'h2);
    axi_rd(4'h6, 32'h0, 2'h2);
    axi_rd(4'h0, 32'h0, 2'h0);
    $display("test regs done");
  endtask
  task automatic t_resolve;
    settle(12'h000, 4'h7, 3'h0, "all active");
    settle(12'h249, 4'h7, 3'h1, "all halted");
    settle(12'hB69, 4'h7, 3'h1, "one halted");
    settle(12'hB68, 4'h7, 3'h0, "one active");
    settle(12'hB6B, 4'h7, 3'h3, "one kept");
    settle(12'h924, 4'h7, 3'h4, "all flushed");
    settle(12'hB6D, 4'h7, 3'h5, "all deepest");
    settle(12'hB6D, 4'h3, 3'h4, "deepest withheld");
    settle(12'h924, 4'h1, 3'h1, "deep withheld");
    settle(12'h924, 4'h0, 3'h0, "no grant");
    settle(12'h492, 4'h7, 3'h2, "all hinted");
    axi_rd(4'h4, 32'h1102, 2'h0);
    $display("test resolve done");
  endtask
  task automatic t_substate;
    axi_wr(4'h0, 32'h1, 2'h0);
    settle(12'h249, 4'h7, 3'h2, "substate");
    chk("clock min", 32'h1, {31'h0, core_clk_min});
    chk("volt low", 32'h1, {31'h0, core_volt_low});
    settle(12'h000, 4'h7, 3'h0, "awake");
    axi_wr(4'h0, 32'h2, 2'h0);
    settle(12'h249, 4'h7, 3'h2, "promoted");
    axi_wr(4'h0, 32'h4, 2'h0);
    settle(12'h924, 4'h7, 3'h2, "limited");
    axi_wr(4'h0, 32'h0, 2'h0);
    $display("test substate done");
  endtask
  // demotion after a break, expiring once the idle count reaches the threshold
  task automatic t_demote;
    axi_wr(4'h0, 32'h8, 2'h0);
    settle(12'h924, 4'h7, 3'h4, "demote idle");
    pulse(4'h0, 4'h0, 1'b1);
    repeat (4) @(posedge aclk);
    chk("demoted", 32'h3, {29'h0, pkg_state});
    repeat (70) @(posedge aclk);
    chk("demote expired", 32'h4, {29'h0, pkg_state});
    axi_wr(4'h0, 32'h0, 2'h0);
    $display("test demote done");
  endtask
  task automatic t_breaks;
    settle(12'h924, 4'h7, 3'h4, "gated");
    pulse(4'h2, 4'h2, 1'b0);
    repeat (4) @(posedge aclk);
    chk("masked return", 32'h4, {29'h0, pkg_state});
    pulse(4'h8, 4'h0, 1'b0);
    settle(12'h124, 4'h7, 3'h0, "unmasked");
    settle(12'hB6D, 4'h7, 3'h5, "deepest again");
    pulse(4'h1, 4'h1, 1'b0);
    settle(12'h924, 4'h7, 3'h4, "regated");
    pulse(4'h0, 4'h0, 1'b1);
    repeat (4) @(posedge aclk);
    chk("memory return", 32'h4, {29'h0, pkg_state});
    lag <= 4'hF;
    settle(12'h924, 4'hF, 3'h4, "hold set");
    pulse(4'h0, 4'h0, 1'b1);
    repeat (6) @(posedge aclk);
    chk("memory hold", 32'h0, {29'h0, pkg_state});
    settle(12'h924, 4'h7, 3'h4, "hold released");
    lag <= 4'h0;
    axi_rd(4'hC, 32'h6, 2'h0);
    $display("test breaks done");
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_resolve;
    t_substate;
    t_demote;
    t_breaks;
    report_and_stop;
  end
endmodule // package_idle_state_resolver_tb
bind package_idle_state_resolver pkg_idle_checker u_pkg_idle_checker (
  .aclk(aclk), .aresetn(aresetn), .core_state(core_state), .core_break(core_break), .core_wake(core_wake),
  .break_forward(break_forward), .standby_permit(standby_permit), .plat_grant(plat_grant),
  .plat_hold_high(plat_hold_high), .mem_break(mem_break), .pkg_ack(pkg_ack), .pkg_state(pkg_state),
  .l2_powered(l2_powered), .core_volt_off(core_volt_off), .sa_power_off(sa_power_off),
  .core_clk_min(core_clk_min), .core_volt_low(core_volt_low));
`default_nettype wire

//--- verification/pkg_idle_checker_assertions.sv
// port-level checks of the package idle-state resolver
`default_nettype none
module pkg_idle_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // core side
  input wire logic [11:0] core_state,
  input wire logic [3:0] core_break,
  input wire logic [3:0] core_wake,
  input wire logic [3:0] break_forward,
  input wire logic [3:0] standby_permit,
  // platform side
  input wire logic plat_grant,
  input wire logic plat_hold_high,
  input wire logic mem_break,
  input wire logic pkg_ack,
  // power actions
  input wire logic [2:0] pkg_state,
  input wire logic l2_powered,
  input wire logic core_volt_off,
  input wire logic sa_power_off,
  input wire logic core_clk_min,
  input wire logic core_volt_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] deep_req;
  logic [3:0] idle_c0;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // per-core decode of deepest and active requests
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      deep_req[i] = core_state[3*i +: 3] == 3'h5;
      idle_c0[i] = core_state[3*i +: 3] == 3'h0;
    end
  end
  // ********
  // checks
  // ********
  a_ack_change: assert property ($changed(pkg_state) |-> pkg_ack)
    else $error("state changed without acknowledge");
  a_active_c0: assert property ((|idle_c0) || !plat_grant |=> pkg_state == 3'h0)
    else $error("package left C0 with an active core or no grant");
  a_gated_power: assert property (core_volt_off == (pkg_state > 3'h3) && l2_powered == !core_volt_off)
    else $error("gated power outputs disagree with state");
  a_deepest_entry: assert property (pkg_state == 3'h5 |-> sa_power_off && $past(core_state) == 12'hB6D)
    else $error("deepest state without all cores deepest");
  a_clk_first: assert property ($rose(core_clk_min) |-> $past(pkg_state) == 3'h2 ##0 (!core_volt_low)[*8])
    else $error("voltage lowered too soon after clock drop");
  a_volt_after_clk: assert property (core_volt_low |-> core_clk_min)
    else $error("voltage low without minimum clock");
  a_wake_forward: assert property (1 |=> core_wake == break_forward &&
    core_wake == ($past(pkg_state) == 3'h0 ? 4'h0 : $past(core_break)))
    else $error("wake or forward mismatch with break");
  a_standby_permit: assert property (1 |=> standby_permit == $past(deep_req))
    else $error("standby permit mismatch");
  a_mem_hold: assert property (mem_break && plat_hold_high |=> pkg_state == 3'h0)
    else $error("held memory break did not give C0");
endmodule // pkg_idle_checker
`default_nettype wire

//--- verification/platform_ctrl_model.sv
// behavioural platform controller granting package states
`default_nettype none
module platform_ctrl_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // wanted levels, extra wait and acknowledge
  input wire logic [3:0] want,
  input wire logic [3:0] lag,
  input wire logic pkg_ack,
  // levels to the device
  output logic plat_grant,
  output logic plat_grant_deep,
  output logic plat_grant_deepest,
  output logic plat_hold_high
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lvl;
  logic [4:0] wait_cnt;
  // grant and hold levels, the hold asks for a higher state
  assign {plat_hold_high, plat_grant_deepest, plat_grant_deep, plat_grant} = lvl;
  // levels move only after the last change was acknowledged or timed out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl <= 4'h0;
      wait_cnt <= 5'h00;
    end else if (wait_cnt != 5'h00) begin
      wait_cnt <= pkg_ack ? 5'h00 : wait_cnt - 5'h01;
    end else if (want != lvl) begin
      lvl <= want;
      wait_cnt <= 5'h10 + {1'b0, lag};
    end
  end
endmodule // platform_ctrl_model
`default_nettype wire

//--- verilog/package_idle_state_resolver.v
// package idle-state resolver with its axi4-lite control registers
`include "pkg_idle_defines.vh"
`default_nettype none

module package_idle_state_resolver (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [3:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read
  input wire [3:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // core side
  input wire [11:0] core_state,
  input wire [3:0] core_break,
  input wire [3:0] core_break_masked,
  output reg [3:0] core_wake,
  output reg [3:0] break_forward,
  output reg [3:0] standby_permit,
  // platform side
  input wire plat_grant,
  input wire plat_grant_deep,
  input wire plat_grant_deepest,
  input wire plat_hold_high,
  input wire mem_break,
  output reg pkg_ack,
  // power actions
  output reg [2:0] pkg_state,
  output reg l2_powered,
  output reg core_volt_off,
  output reg sa_power_off,
  output reg core_clk_min,
  output reg core_volt_low
);

  // ****************************************************************
  // one-hot package states
  // ****************************************************************
  localparam [5:0] ST_C0 = 6'h01;
  localparam [5:0] ST_C1 = 6'h02;
  localparam [5:0] ST_HALT_LF = 6'h04;
  localparam [5:0] ST_COND = 6'h08;
  localparam [5:0] ST_GATED = 6'h10;
  localparam [5:0] ST_DEEPEST = 6'h20;
  // full-width step count, cut to the counter width on purpose
  localparam [31:0] VOLT_CYC_FULL = `VOLT_STEP_CYC;
  localparam [3:0] VOLT_CYC = VOLT_CYC_FULL[3:0];

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // depth of one core request, hint counts as c1
  function [2:0] depth;
    input [2:0] cs;
    begin
      if (cs == `CS_HINT) begin
        depth = `CS_C1;
      end else begin
        depth = cs;
      end
    end
  endfunction

  // shallower of two depths
  function [2:0] shallower;
    input [2:0] a;
    input [2:0] b;
    begin
      shallower = (a < b) ? a : b;
    end
  endfunction

  // register index of a byte address, 3'h7 when unmapped
  function [2:0] reg_index;
    input [3:0] addr;
    begin
      if (addr == `OFF_CTRL) begin
        reg_index = 3'h0;
      end else if (addr == `OFF_STATUS) begin
        reg_index = 3'h1;
      end else if (addr == `OFF_DEMOTE) begin
        reg_index = 3'h2;
      end else if (addr == `OFF_BREAKS) begin
        reg_index = 3'h3;
      end else begin
        reg_index = 3'h7;
      end
    end
  endfunction

  // code of a one-hot state
  function [2:0] code_of;
    input [5:0] st;
    begin
      case (st)
        ST_C1: code_of = `PK_C1;
        ST_HALT_LF: code_of = `PK_HALT_LF;
        ST_COND: code_of = `PK_COND;
        ST_GATED: code_of = `PK_GATED;
        ST_DEEPEST: code_of = `PK_DEEPEST;
        default: code_of = `PK_C0;
      endcase
    end
  endfunction

  // one-hot state of a code
  function [5:0] state_of;
    input [2:0] code;
    begin
      case (code)
        `PK_C1: state_of = ST_C1;
        `PK_HALT_LF: state_of = ST_HALT_LF;
        `PK_COND: state_of = ST_COND;
        `PK_GATED: state_of = ST_GATED;
        `PK_DEEPEST: state_of = ST_DEEPEST;
        default: state_of = ST_C0;
      endcase
    end
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg [3:0] ctrl;
  reg [15:0] demote_thresh;
  reg [15:0] break_count;
  reg [15:0] idle_cnt;
  reg [5:0] state;
  reg [5:0] next_state;
  reg [2:0] prev_code;
  reg retry;
  reg next_retry;
  reg [3:0] volt_cnt;
  reg aw_got;
  reg w_got;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [2:0] mod_a;
  reg [2:0] mod_b;
  reg [2:0] resolved;
  reg [3:0] all_hint_v;
  reg [3:0] all_c1_v;
  wire [3:0] is_hint;
  wire [3:0] is_c1;
  wire [3:0] is_deepest;
  wire [3:0] brk;
  wire idle;

  // ****************************************************************
  // per-core decode
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_core
      assign is_hint[gi] = (core_state[3*gi+2:3*gi] == `CS_HINT);
      assign is_c1[gi] = (core_state[3*gi+2:3*gi] == `CS_C1);
      assign is_deepest[gi] = (core_state[3*gi+2:3*gi] == `CS_DEEPEST);
    end
  endgenerate

  assign idle = (state != ST_C0);
  assign brk = core_break & {4{idle}};

  // ****************************************************************
  // package resolution
  // ****************************************************************
  always @* begin
    // each core pair is one module at its lowest request
    mod_a = shallower(depth(core_state[2:0]), depth(core_state[5:3]));
    mod_b = shallower(depth(core_state[8:6]), depth(core_state[11:9]));
    all_hint_v = is_hint;
    all_c1_v = is_c1;
    // module pair table
    if (mod_a == `CS_C0 || mod_b == `CS_C0) begin
      resolved = `PK_C0;
    end else if (mod_a == `CS_C1 || mod_b == `CS_C1) begin
      resolved = `PK_C1;
    end else if (mod_a == `CS_KEPT || mod_b == `CS_KEPT) begin
      resolved = `PK_COND;
    end else if (mod_a == `CS_DEEPEST && mod_b == `CS_DEEPEST) begin
      resolved = `PK_DEEPEST;
    end else begin
      resolved = `PK_GATED;
    end
    // deep states need grants, else stay shallower
    if (resolved == `PK_DEEPEST && !plat_grant_deepest) begin
      resolved = `PK_GATED;
    end
    if (resolved >= `PK_COND && !plat_grant_deep) begin
      resolved = `PK_C1;
    end
    // heuristic demotion after recent break activity
    if (resolved >= `PK_GATED && ctrl[`CTRL_DEMOTE_EN] && idle_cnt < demote_thresh) begin
      resolved = `PK_COND;
    end
    // limit to the c1 family
    if (resolved >= `PK_COND && ctrl[`CTRL_LIMIT_C1]) begin
      resolved = `PK_HALT_LF;
    end
    // substate selection within c1
    if (resolved == `PK_C1) begin
      if (ctrl[`CTRL_SUBSTATE_EN] || &all_hint_v ||
          (ctrl[`CTRL_AUTO_PROMOTE] && &all_c1_v)) begin
        resolved = `PK_HALT_LF;
      end
    end
    if (!plat_grant) begin
      resolved = `PK_C0;
    end
  end

  // ****************************************************************
  // next package state
  // ****************************************************************
  always @* begin
    next_state = state_of(resolved);
    next_retry = 1'b0;
    if (plat_hold_high && (mem_break || state == ST_C0) && retry) begin
      next_state = ST_C0;
      next_retry = 1'b1;
    end else if (plat_hold_high && mem_break && idle) begin
      next_state = ST_C0;
      next_retry = 1'b1;
    end else if ((brk & ~core_break_masked) != 4'h0) begin
      next_state = ST_C0;
    end else if (brk != 4'h0 || (mem_break && idle)) begin
      next_state = ST_C0;
      next_retry = 1'b1;
    end else if (retry) begin
      next_state = state_of(shallower(prev_code, resolved));
    end
  end

  // ****************************************************************
  // state register and break handling
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_C0;
      prev_code <= `PK_C0;
      retry <= 1'b0;
      core_wake <= 4'h0;
      break_forward <= 4'h0;
      pkg_ack <= 1'b0;
      idle_cnt <= 16'h0000;
      break_count <= 16'h0000;
    end else begin
      state <= next_state;
      retry <= next_retry;
      if (next_retry && !retry) begin
        prev_code <= code_of(state);
      end
      core_wake <= brk;
      break_forward <= brk;
      // one pulse per transition, platform levels held until it or until the platform wait times out
      pkg_ack <= (next_state != state);
      if (brk != 4'h0 || mem_break) begin
        idle_cnt <= 16'h0000;
        break_count <= break_count + 16'h0001;
      end else if (idle_cnt != 16'hFFFF) begin
        idle_cnt <= idle_cnt + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // power actions, no system notification for c1 entries
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      pkg_state <= `PK_C0;
      l2_powered <= 1'b1;
      core_volt_off <= 1'b0;
      sa_power_off <= 1'b0;
      standby_permit <= 4'h0;
    end else begin
      pkg_state <= code_of(next_state);
      l2_powered <= !(next_state == ST_GATED || next_state == ST_DEEPEST);
      core_volt_off <= (next_state == ST_GATED || next_state == ST_DEEPEST);
      sa_power_off <= (next_state == ST_DEEPEST);
      standby_permit <= is_deepest;
    end
  end

  // ****************************************************************
  // low-frequency halt: clock first, voltage later
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_clk_min <= 1'b0;
      core_volt_low <= 1'b0;
      volt_cnt <= 4'h0;
    end else if (state != ST_HALT_LF) begin
      core_clk_min <= 1'b0;
      core_volt_low <= 1'b0;
      volt_cnt <= VOLT_CYC;
    end else begin
      core_clk_min <= 1'b1;
      if (volt_cnt != 4'h0) begin
        volt_cnt <= volt_cnt - 4'h1;
      end else begin
        core_volt_low <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // axi4-lite write channel
  // ****************************************************************
  assign awready = !aw_got && !bvalid;
  assign wready = !w_got && !bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      ctrl <= `CTRL_RESET;
      demote_thresh <= `DEMOTE_RESET;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (aw_got && w_got) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= `RESP_OKAY;
        if (reg_index(aw_addr) == 3'h0) begin
          if (w_strb[0]) begin
            ctrl <= w_data[3:0];
          end
        end else if (reg_index(aw_addr) == 3'h2) begin
          if (w_strb[0]) begin
            demote_thresh[7:0] <= w_data[7:0];
          end
          if (w_strb[1]) begin
            demote_thresh[15:8] <= w_data[15:8];
          end
        end else if (reg_index(aw_addr) == 3'h7) begin
          bresp <= `RESP_SLVERR;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // axi4-lite read channel
  // ****************************************************************
  assign arready = !rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= `RESP_OKAY;
      if (reg_index(araddr) == 3'h0) begin
        rdata <= {28'h0000000, ctrl};
      end else if (reg_index(araddr) == 3'h1) begin
        rdata <= {16'h0000, 1'b0, mod_b, 1'b0, mod_a, 1'b0, prev_code, 1'b0, pkg_state};
      end else if (reg_index(araddr) == 3'h2) begin
        rdata <= {16'h0000, demote_thresh};
      end else if (reg_index(araddr) == 3'h3) begin
        rdata <= {16'h0000, break_count};
      end else begin
        rdata <= 32'h00000000;
        rresp <= `RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // package_idle_state_resolver

`default_nettype wire

//--- verilog/pkg_idle_defines.vh
// constants, codes and register map of the package idle-state resolver
//
// Behaviour
// - package request is lowest core state
// - without platform permission, package stays shallower
// - idle states change directly, not via C0
// - heuristic may demote deep request to shallower
// - break while idle wakes core, forwards message
// - unmasked core break: core and package C0
// - masked core break: retry previous package state
// - memory or snoop break: return to previous
// - platform hold request keeps package higher
// - two module states combine into package state
// - substate enabled: low-frequency halt replaces C1
// - conditional deep state keeps L2 powered
// - each two cores form one module
// - any core C0 or no permission: C0
// - halt substate: clock down first, then voltage
// - C1 when one core C1, others deeper
// - three cases enter low-frequency halt substate; the code also enters it when the C1 limit cuts a deeper request
// - no system notification on C1 entries
// - gated deep needs its grant, not deepest
// - gated deep: cores saved, voltage removed
// - deepest state only if all cores deepest
// - deepest handles core breaks like gated deep
// - deepest core grants platform standby permission
`ifndef PKG_IDLE_DEFINES_VH
`define PKG_IDLE_DEFINES_VH

// ****************************************************************
// core request codes
// ****************************************************************
`define CS_C0 3'h0
`define CS_C1 3'h1
`define CS_HINT 3'h2
`define CS_KEPT 3'h3
`define CS_FLUSH 3'h4
`define CS_DEEPEST 3'h5

// ****************************************************************
// package state codes, ordered shallow to deep
// ****************************************************************
`define PK_C0 3'h0
`define PK_C1 3'h1
`define PK_HALT_LF 3'h2
`define PK_COND 3'h3
`define PK_GATED 3'h4
`define PK_DEEPEST 3'h5

// ****************************************************************
// register map and fields
// ****************************************************************
`define OFF_CTRL 4'h0
`define OFF_STATUS 4'h4
`define OFF_DEMOTE 4'h8
`define OFF_BREAKS 4'hC
`define CTRL_SUBSTATE_EN 0
`define CTRL_AUTO_PROMOTE 1
`define CTRL_LIMIT_C1 2
`define CTRL_DEMOTE_EN 3
`define CTRL_RESET 4'h0
`define DEMOTE_RESET 16'h0040
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************************************
// timing
// ****************************************************************
`define CLK_KHZ 10000
`define VOLT_STEP_NS 1000
`define VOLT_STEP_CYC ((`VOLT_STEP_NS * `CLK_KHZ + 999999) / 1000000)

`endif
